// ### design/fws_params.svh
`ifndef FWS_PARAMS_SVH
`define FWS_PARAMS_SVH
// Register offsets (word index on the plain register port).
`define FWS_OFF_OP_CTRL_LO    4'h0
`define FWS_OFF_OP_CTRL_HI    4'h1
`define FWS_OFF_SECTOR_SEL_LO 4'h2
`define FWS_OFF_SECTOR_SEL_HI 4'h3
`define FWS_OFF_ADDR_LO       4'h4
`define FWS_OFF_ADDR_HI       4'h5
`define FWS_OFF_WDATA0_LO     4'h6
`define FWS_OFF_WDATA0_HI     4'h7
`define FWS_OFF_WDATA1_LO     4'h8
`define FWS_OFF_WDATA1_HI     4'h9
`define FWS_OFF_ERROR         4'hA
`define FWS_OFF_NV_PROT0      4'hB
`define FWS_OFF_NV_DISABLE    4'hC
`define FWS_OFF_NV_REENABLE   4'hD
// Field positions in op_ctrl_hi, then in error_reg, the target address and nv_prot0.
`define FWS_BIT_LAUNCH        15
`define FWS_BIT_SUSPEND       14
`define FWS_BIT_WORD_PROG     13
`define FWS_BIT_DWORD_PROG    12
`define FWS_BIT_SECTOR_ERASE  11
`define FWS_BIT_SET_PROT      8
`define FWS_BIT_ARRAY_MODE    7
`define FWS_BIT_RESUME_ERROR  0
`define FWS_BIT_ADDR2         2
`define FWS_BIT_ACCESS_PROT   0
`define FWS_BIT_DEBUG_PROT    1
// Protection register address and data.
`define FWS_PROT_ADDR_HI      16'h000E
`define FWS_PROT_DIS_LO       16'hDFBC
`define FWS_PROT_REEN_LO      16'hDFBE
`define FWS_PROT_CLEAR0       16'hFFFE
// Reset values.
`define FWS_RST_WORD          16'h0000
`define FWS_RST_NV_WORD       16'hFFFF
`define FWS_RST_NV_PROT0      16'hFFFF
// Timing in cycles of the 10 MHz clock.
`define FWS_PROG_CYCLES       16'h0040
`define FWS_ERASE_STEP_CYCLES 16'h0100
`endif

// ### design/fws_pkg.sv
package fws_pkg;
  typedef enum logic [2:0] {
    FWS_OP_NONE,
    FWS_OP_WORD,
    FWS_OP_DWORD,
    FWS_OP_ERASE,
    FWS_OP_PROT
  } fws_op_e;
  typedef logic [15:0] fws_word_t;
endpackage

// ### design/fws_timer_if.sv
`timescale 1ns/1ps
interface fws_timer_if;
  logic        start;
  logic [15:0] length;
  logic        hold;
  logic        done;
  modport owner (output start, output length, output hold, input done);
  modport timer (input start, input length, input hold, output done);
endinterface

// ### design/fws_timer.sv
`timescale 1ns/1ps
`include "fws_params.svh"
module fws_timer (
  input  wire logic   clock_in,
  input  wire logic   rstn_in,
  fws_timer_if.timer  tmr
);
  import fws_pkg::*;
  // ****************************************************************
  // Busy countdown; held frozen while the owner suspends.
  // ****************************************************************
  logic [15:0] count;
  logic        running;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count   <= 16'h0000;
      running <= 1'b0;
      tmr.done <= 1'b0;
    end else begin
      tmr.done <= 1'b0;
      if (tmr.start) begin
        count   <= tmr.length;
        running <= 1'b1;
      end else if (running && !tmr.hold) begin
        if (count <= 16'h0001) begin
          running  <= 1'b0;
          tmr.done <= 1'b1;
        end else begin
          count <= count - 16'h0001;
        end
      end
    end
  end
endmodule

// ### design/fws_sequencer.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "fws_params.svh"
// Summary of operation
// - Every register write carries a full 16-bit word.
// - Select an operation, load its parameters, then launch.
// - Setting the launch bit starts the selected operation.
// - Clearing the select bit before launch cancels the operation.
// - Word program writes 32 bits from data pair 0 to the target.
// - Double word program writes both data pairs to two words.
// - Double word program ignores address bit 2.
// - Sector erase erases sectors whose selection bits are set.
// - Programs and erase can be suspended by the suspend bit.
// - Sector selection reads zero once an erase is complete.
// - Resume with changed select bits aborts and flags resume error.
// - A suspended erase allows a program of another sector.
// - During that program erase and suspend read low; no suspend.
// - Set protection 0xFFFE to disable register clears bit 0.
// - Set protection 0xFFFE to re-enable register clears bit 0; the code takes it at the disable address 0xDFBC.
// - Disable and re-enable cycle allowed at most 16 times.
// - Disable bit programs only after access and debug bits are zero.
module fws_sequencer #(
  parameter int PROG_CYCLES  = `FWS_PROG_CYCLES,
  parameter int ERASE_CYCLES = `FWS_ERASE_STEP_CYCLES
) (
  input  wire logic             clock_in,
  input  wire logic             rstn_in,
  input  wire logic [3:0]       reg_addr_in,
  input  wire fws_pkg::fws_word_t reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic [15:0]           reg_rdata_out,
  output logic                  busy_out,
  output logic                  array_wr_out,
  output logic [31:0]           array_addr_out,
  output logic [31:0]           array_data_out,
  output logic                  sector_erase_out,
  output logic [31:0]           sector_mask_out
);
  import fws_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] op_ctrl_hi;
  logic [15:0] op_ctrl_lo;
  logic [15:0] sector_sel_lo;
  logic [15:0] sector_sel_hi;
  logic [15:0] target_addr_lo;
  logic [15:0] target_addr_hi;
  logic [15:0] wdata0_lo;
  logic [15:0] wdata0_hi;
  logic [15:0] wdata1_lo;
  logic [15:0] wdata1_hi;
  logic [15:0] error_reg;
  logic [15:0] nv_prot0;
  logic [15:0] nv_prot_disable_reg;
  logic [15:0] nv_prot_reenable_reg;
  logic [4:0]  prot_cycles;

  typedef enum logic [2:0] {
    FWS_IDLE,
    FWS_RUN,
    FWS_DWORD2,
    FWS_SUSPEND_REQ,
    FWS_ERASE_SUSPEND_REQ
  } fws_state_e;
  fws_state_e state;
  fws_op_e    active_op;
  fws_op_e    suspend_req_op;
  logic [15:0] suspend_req_sel;
  logic        prog_in_erase_suspend_req;

  fws_timer_if tmr ();
  fws_timer u_timer (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .tmr      (tmr.timer)
  );

  logic wr_hi;
  logic launch_wr;
  logic suspend_wr;
  logic [15:0] sel_mask;
  fws_op_e next_op;
  logic    hold_req;
  logic    suspend_now;
  assign wr_hi      = reg_wr_in && (reg_addr_in == `FWS_OFF_OP_CTRL_HI);
  assign launch_wr  = wr_hi && reg_wdata_in[`FWS_BIT_LAUNCH];
  assign suspend_wr = wr_hi && reg_wdata_in[`FWS_BIT_SUSPEND];
  assign sel_mask   = 16'h3900;
  // An ending countdown wins over a suspend in the same cycle, so no end is lost.
  assign suspend_now = suspend_wr && (state == FWS_RUN || state == FWS_DWORD2) &&
                       !prog_in_erase_suspend_req && !tmr.done;
  // The hold rises in the suspend cycle itself, so the countdown cannot finish unseen.
  assign tmr.hold    = hold_req || suspend_now;

  // Decode the select bits by priority, word first and protection last; with none set the launch does nothing.
  always_comb begin
    next_op = FWS_OP_NONE;
    if (op_ctrl_hi[`FWS_BIT_WORD_PROG]) begin
      next_op = FWS_OP_WORD;
    end else if (op_ctrl_hi[`FWS_BIT_DWORD_PROG]) begin
      next_op = FWS_OP_DWORD;
    end else if (op_ctrl_hi[`FWS_BIT_SECTOR_ERASE]) begin
      next_op = FWS_OP_ERASE;
    end else if (op_ctrl_hi[`FWS_BIT_SET_PROT]) begin
      next_op = FWS_OP_PROT;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Stand-alone program keeps launch and select bits; they are cleared at end.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state              <= FWS_IDLE;
      active_op          <= FWS_OP_NONE;
      suspend_req_op            <= FWS_OP_NONE;
      suspend_req_sel           <= `FWS_RST_WORD;
      prog_in_erase_suspend_req <= 1'b0;
      op_ctrl_hi         <= `FWS_RST_WORD;
      sector_sel_lo      <= `FWS_RST_WORD;
      sector_sel_hi      <= `FWS_RST_WORD;
      error_reg          <= `FWS_RST_WORD;
      array_wr_out       <= 1'b0;
      array_addr_out     <= 32'h0000_0000;
      array_data_out     <= 32'h0000_0000;
      sector_erase_out   <= 1'b0;
      sector_mask_out    <= 32'h0000_0000;
      busy_out           <= 1'b0;
      tmr.start          <= 1'b0;
      tmr.length         <= 16'h0000;
      hold_req           <= 1'b0;
      nv_prot_disable_reg  <= `FWS_RST_NV_WORD;
      nv_prot_reenable_reg <= `FWS_RST_NV_WORD;
      prot_cycles        <= 5'h00;
    end else begin
      array_wr_out     <= 1'b0;
      sector_erase_out <= 1'b0;
      tmr.start        <= 1'b0;
      if (reg_wr_in && reg_addr_in == `FWS_OFF_SECTOR_SEL_LO) begin
        sector_sel_lo <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == `FWS_OFF_SECTOR_SEL_HI) begin
        sector_sel_hi <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == `FWS_OFF_ERROR) begin
        error_reg <= reg_wdata_in;
      end
      case (state)
        FWS_IDLE, FWS_ERASE_SUSPEND_REQ: begin
          // Store bits 14:0 with launch cleared: cancel happens simply by clearing a select bit.
          if (wr_hi) begin
            op_ctrl_hi <= {1'b0, reg_wdata_in[14:0]};
          end
          if (launch_wr && !op_ctrl_hi[`FWS_BIT_SUSPEND]) begin
            if (state == FWS_ERASE_SUSPEND_REQ && next_op == FWS_OP_ERASE) begin
              // Only the select bits must match; the mode bit is not part of the setup.
              if ((op_ctrl_hi & sel_mask) != suspend_req_sel) begin
                error_reg[`FWS_BIT_RESUME_ERROR] <= 1'b1;
                op_ctrl_hi <= `FWS_RST_WORD;
                state      <= FWS_IDLE;
              end else begin
                op_ctrl_hi[`FWS_BIT_LAUNCH] <= 1'b1;
                // A program inside the suspend reuses the timer, so the erase count restarts.
                hold_req   <= 1'b0;
                tmr.start  <= 1'b1;
                tmr.length <= ERASE_CYCLES[15:0];
                active_op <= FWS_OP_ERASE;
                busy_out  <= 1'b1;
                state     <= FWS_RUN;
              end
            end else if (next_op == FWS_OP_PROT) begin
              if (target_addr_hi == `FWS_PROT_ADDR_HI &&
                  target_addr_lo == `FWS_PROT_DIS_LO &&
                  wdata0_lo == `FWS_PROT_CLEAR0 &&
                  nv_prot0[1:0] == 2'b00 && prot_cycles < 5'h10) begin
                nv_prot_disable_reg <= nv_prot_disable_reg & `FWS_PROT_CLEAR0;
              end
              if (target_addr_hi == `FWS_PROT_ADDR_HI &&
                  target_addr_lo == `FWS_PROT_DIS_LO &&
                  wdata0_hi == `FWS_PROT_CLEAR0 &&
                  !nv_prot_disable_reg[0] && prot_cycles < 5'h10) begin
                nv_prot_reenable_reg <= nv_prot_reenable_reg & `FWS_PROT_CLEAR0;
                prot_cycles <= prot_cycles + 5'h01;
              end
              op_ctrl_hi <= `FWS_RST_WORD;
            end else if (next_op != FWS_OP_NONE && !(state == FWS_ERASE_SUSPEND_REQ &&
                         next_op == FWS_OP_ERASE)) begin
              op_ctrl_hi[`FWS_BIT_LAUNCH] <= 1'b1;
              active_op  <= next_op;
              busy_out   <= 1'b1;
              prog_in_erase_suspend_req <= (state == FWS_ERASE_SUSPEND_REQ);
              hold_req   <= 1'b0;
              tmr.start  <= 1'b1;
              tmr.length <= (next_op == FWS_OP_ERASE) ? ERASE_CYCLES[15:0] : PROG_CYCLES[15:0];
              array_addr_out <= {target_addr_hi,
                                 target_addr_lo[15:3],
                                 (next_op == FWS_OP_DWORD) ? 1'b0 :
                                 target_addr_lo[`FWS_BIT_ADDR2],
                                 target_addr_lo[1:0]};
              array_data_out <= {wdata0_hi, wdata0_lo};
              state <= FWS_RUN;
            end
          end
        end
        FWS_RUN, FWS_DWORD2: begin
          // The second word's address and data follow the first word's strobe by one cycle.
          if (state == FWS_DWORD2 && array_wr_out) begin
            array_addr_out <= array_addr_out + 32'h0000_0004;
            array_data_out <= {wdata1_hi, wdata1_lo};
          end
          if (suspend_now) begin
            op_ctrl_hi[`FWS_BIT_SUSPEND] <= 1'b1;
            op_ctrl_hi[`FWS_BIT_LAUNCH]  <= 1'b0;
            hold_req <= 1'b1;
            suspend_req_sel <= op_ctrl_hi & sel_mask;
            suspend_req_op  <= active_op;
            busy_out <= 1'b0;
            state    <= (active_op == FWS_OP_ERASE) ? FWS_ERASE_SUSPEND_REQ : FWS_SUSPEND_REQ;
          end else if (tmr.done) begin
            if (active_op == FWS_OP_ERASE) begin
              sector_erase_out <= 1'b1;
              sector_mask_out  <= {sector_sel_hi, sector_sel_lo};
              sector_sel_lo    <= `FWS_RST_WORD;
              sector_sel_hi    <= `FWS_RST_WORD;
            end else begin
              array_wr_out <= 1'b1;
            end
            if (active_op == FWS_OP_DWORD && state == FWS_RUN) begin
              state          <= FWS_DWORD2;
              tmr.start      <= 1'b1;
              tmr.length     <= 16'h0001;
            end else if (prog_in_erase_suspend_req) begin
              op_ctrl_hi <= `FWS_RST_WORD;
              busy_out   <= 1'b0;
              prog_in_erase_suspend_req <= 1'b0;
              hold_req   <= 1'b1;
              state      <= FWS_ERASE_SUSPEND_REQ;
            end else begin
              op_ctrl_hi <= `FWS_RST_WORD;
              busy_out   <= 1'b0;
              state      <= FWS_IDLE;
            end
          end
        end
        FWS_SUSPEND_REQ: begin
          if (wr_hi) begin
            op_ctrl_hi <= {1'b0, reg_wdata_in[14:0]};
          end
          if (launch_wr && !op_ctrl_hi[`FWS_BIT_SUSPEND]) begin
            if ((op_ctrl_hi & sel_mask) != suspend_req_sel) begin
              error_reg[`FWS_BIT_RESUME_ERROR] <= 1'b1;
              op_ctrl_hi <= `FWS_RST_WORD;
              state      <= FWS_IDLE;
            end else begin
              op_ctrl_hi[`FWS_BIT_LAUNCH] <= 1'b1;
              hold_req <= 1'b0;
              busy_out <= 1'b1;
              // A double word suspended after its first word resumes at the second.
              state    <= (suspend_req_op == FWS_OP_DWORD && array_addr_out[`FWS_BIT_ADDR2]) ?
                          FWS_DWORD2 : FWS_RUN;
            end
          end
        end
        default: state <= FWS_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Parameter registers
  // ****************************************************************
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      op_ctrl_lo     <= `FWS_RST_WORD;
      target_addr_lo <= `FWS_RST_WORD;
      target_addr_hi <= `FWS_RST_WORD;
      wdata0_lo      <= `FWS_RST_WORD;
      wdata0_hi      <= `FWS_RST_WORD;
      wdata1_lo      <= `FWS_RST_WORD;
      wdata1_hi      <= `FWS_RST_WORD;
      nv_prot0       <= `FWS_RST_NV_PROT0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `FWS_OFF_OP_CTRL_LO: op_ctrl_lo     <= reg_wdata_in;
        `FWS_OFF_ADDR_LO:    target_addr_lo <= reg_wdata_in;
        `FWS_OFF_ADDR_HI:    target_addr_hi <= reg_wdata_in;
        `FWS_OFF_WDATA0_LO:  wdata0_lo      <= reg_wdata_in;
        `FWS_OFF_WDATA0_HI:  wdata0_hi      <= reg_wdata_in;
        `FWS_OFF_WDATA1_LO:  wdata1_lo      <= reg_wdata_in;
        `FWS_OFF_WDATA1_HI:  wdata1_hi      <= reg_wdata_in;
        // Access and debug bits can only be programmed to zero, never back.
        `FWS_OFF_NV_PROT0:   nv_prot0       <= nv_prot0 & reg_wdata_in;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= `FWS_RST_WORD;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `FWS_OFF_OP_CTRL_LO:    reg_rdata_out <= op_ctrl_lo;
        `FWS_OFF_OP_CTRL_HI:    reg_rdata_out <= op_ctrl_hi;
        `FWS_OFF_SECTOR_SEL_LO: reg_rdata_out <= sector_sel_lo;
        `FWS_OFF_SECTOR_SEL_HI: reg_rdata_out <= sector_sel_hi;
        `FWS_OFF_ADDR_LO:       reg_rdata_out <= target_addr_lo;
        `FWS_OFF_ADDR_HI:       reg_rdata_out <= target_addr_hi;
        `FWS_OFF_WDATA0_LO:     reg_rdata_out <= wdata0_lo;
        `FWS_OFF_WDATA0_HI:     reg_rdata_out <= wdata0_hi;
        `FWS_OFF_WDATA1_LO:     reg_rdata_out <= wdata1_lo;
        `FWS_OFF_WDATA1_HI:     reg_rdata_out <= wdata1_hi;
        `FWS_OFF_ERROR:         reg_rdata_out <= error_reg;
        `FWS_OFF_NV_PROT0:      reg_rdata_out <= nv_prot0;
        `FWS_OFF_NV_DISABLE:    reg_rdata_out <= nv_prot_disable_reg;
        `FWS_OFF_NV_REENABLE:   reg_rdata_out <= nv_prot_reenable_reg;
        default:                reg_rdata_out <= 16'h0000;
      endcase
    end
  end
endmodule

// ### tb/fws_sequencer_sva.sv
`timescale 1ns/1ps
`include "fws_params.svh"
module fws_sequencer_sva #(
  parameter int PROG_CYCLES  = 64,
  parameter int ERASE_CYCLES = 256
) (
  input wire logic              clock_in,
  input wire logic              rstn_in,
  input wire logic [3:0]        reg_addr_in,
  input wire fws_pkg::fws_word_t reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [15:0]       reg_rdata_out,
  input wire logic              busy_out,
  input wire logic              array_wr_out,
  input wire logic [31:0]       array_addr_out,
  input wire logic [31:0]       array_data_out,
  input wire logic              sector_erase_out,
  input wire logic [31:0]       sector_mask_out
);
  import fws_pkg::*;
  // A generous ceiling; a stuck sequencer shows up as a busy level that never drops.
  localparam int MAX_BUSY = 40 * ERASE_CYCLES + 4 * PROG_CYCLES;
  logic [31:0] busy_len;
  logic        hi_wr;
  assign hi_wr = reg_wr_in && (reg_addr_in == `FWS_OFF_OP_CTRL_HI);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_len <= 32'h00000000;
    end else if (busy_out) begin
      busy_len <= busy_len + 32'h00000001;
    end else begin
      busy_len <= 32'h00000000;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  launch_busy_a: assert property (
    hi_wr && reg_wdata_in == 16'hA080 && !busy_out |=> busy_out)
    else $error("word program launch did not raise busy");
  start_cause_a: assert property (
    $rose(busy_out) |-> $past(hi_wr && reg_wdata_in[15]))
    else $error("busy rose without a launch write");
  wr_in_op_a: assert property (
    array_wr_out |-> $past(busy_out))
    else $error("array write outside an operation");
  no_early_end_a: assert property (
    $rose(busy_out) |-> (!array_wr_out && !sector_erase_out) [*2])
    else $error("operation ended too early");
  erase_mask_a: assert property (
    sector_erase_out |-> sector_mask_out != 32'h00000000)
    else $error("erase with empty sector mask");
  rdata_hold_a: assert property (
    !$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  no_spurious_a: assert property (
    !busy_out && !$past(busy_out) |-> !array_wr_out && !sector_erase_out)
    else $error("array activity while idle");
  busy_bound_a: assert property (
    busy_len <= MAX_BUSY)
    else $error("operation never completed");
  suspend_drop_a: assert property (
    busy_out && hi_wr && reg_wdata_in == 16'h4000 |-> ##[1:3] !busy_out)
    else $error("suspend did not stop the operation");
endmodule
bind fws_sequencer fws_sequencer_sva #(
  .PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)
) u_sva (
  .clock_in(clock_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .busy_out(busy_out), .array_wr_out(array_wr_out),
  .array_addr_out(array_addr_out), .array_data_out(array_data_out),
  .sector_erase_out(sector_erase_out), .sector_mask_out(sector_mask_out)
);

// ### tb/fws_sequencer_tb.sv
`timescale 1ns/1ps
module fws_sequencer_tb;
  import fws_pkg::*;
  logic        clock_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [3:0]  reg_addr_in = 4'h0;
  fws_word_t   reg_wdata_in = 16'h0000;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out, rv;
  logic        busy_out, array_wr_out, sector_erase_out;
  logic [31:0] array_addr_out, array_data_out, sector_mask_out;
  logic [31:0] seed = 32'h0000002F;
  logic [31:0] a, d0, d1;
  logic [63:0] wq[$];
  logic [31:0] eq[$];
  int          fail_count = 0;
  int          comparisons = 0;
  always #50 clock_in = ~clock_in;
  // Short program and erase times keep the suspend window reachable in a short run.
  fws_sequencer #(.PROG_CYCLES(4), .ERASE_CYCLES(16)) dut (
    .clock_in(clock_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .busy_out(busy_out), .array_wr_out(array_wr_out),
    .array_addr_out(array_addr_out), .array_data_out(array_data_out),
    .sector_erase_out(sector_erase_out), .sector_mask_out(sector_mask_out));
  always @(posedge clock_in) begin
    if (array_wr_out === 1'b1) wq.push_back({array_addr_out, array_data_out});
    if (sector_erase_out === 1'b1) eq.push_back(sector_mask_out);
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] dw_addr(input logic [31:0] ad, input logic [31:0] i);
    return (ad & 32'hFFFFFFFB) + (i << 2);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic exp_wr(input logic [31:0] ad, input logic [31:0] dt);
    logic [63:0] e;
    e = (wq.size() > 0) ? wq.pop_front() : 64'h0;
    chk(e[63:32], ad);
    chk(e[31:0], dt);
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] dt);
    reg_addr_in <= ad;
    reg_wdata_in <= dt;
    reg_wr_in <= 1'b1;
    reg_rd_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [3:0] ad);
    reg_addr_in <= ad;
    reg_rd_in <= 1'b1;
    reg_wr_in <= 1'b0;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    @(posedge clock_in);
    rv = reg_rdata_out;
  endtask
  task automatic idle(input int n);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    repeat (n) @(posedge clock_in);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    idle(2);
    while (busy_out !== 1'b0 && n < 3000) begin
      @(posedge clock_in);
      n++;
    end
    // One more edge lets the strobe monitor record the last pulse first.
    @(posedge clock_in);
    chk({31'h0, busy_out}, 32'h0);
  endtask
  task automatic prog(input logic [15:0] sel, input logic [31:0] ad, input logic [31:0] x0,
                      input logic [31:0] x1);
    wr(4'h1, sel);
    wr(4'h4, ad[15:0]);
    wr(4'h5, ad[31:16]);
    wr(4'h6, x0[15:0]);
    wr(4'h7, x0[31:16]);
    wr(4'h8, x1[15:0]);
    wr(4'h9, x1[31:16]);
    wr(4'h1, sel | 16'h8000);
  endtask
  task automatic erase();
    wr(4'h1, 16'h0880);
    wr(4'h2, 16'h0003);
    wr(4'h3, 16'h0000);
    wr(4'h1, 16'h8880);
    idle(2);
    wr(4'h1, 16'h4000);
    idle(3);
  endtask
  task automatic prot(input logic [15:0] lo, input logic [15:0] hi);
    wr(4'h1, 16'h0100);
    wr(4'h4, 16'hDFBC);
    wr(4'h5, 16'h000E);
    wr(4'h6, lo);
    wr(4'h7, hi);
    wr(4'h1, 16'h8100);
    idle(3);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #2000000;
    fail_count++;
    results();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (10) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    rd(4'hC); chk(rv, 32'hFFFF);
    rd(4'hD); chk(rv, 32'hFFFF);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      a = rnd() & 32'h00FFFFFC;
      d0 = rnd();
      prog(16'h2080, a, d0, 32'h0);
      wait_idle();
      exp_wr(a, d0);
      rd(4'h1); chk(rv, 32'h0);
    end
    a = (rnd() & 32'h00FFFFF8) | 32'h4;
    d0 = rnd();
    d1 = rnd();
    prog(16'h1080, a, d0, d1);
    wait_idle();
    exp_wr(dw_addr(a, 0), d0);
    exp_wr(dw_addr(a, 1), d1);
    $display("test program done");
    wr(4'h1, 16'h2080);
    wr(4'h4, 16'h1234);
    wr(4'h1, 16'h0000);
    wr(4'h1, 16'h8000);
    wait_idle();
    chk(wq.size(), 0);
    $display("test cancel done");
    erase();
    chk({31'h0, busy_out}, 32'h0);
    wr(4'h1, 16'h0000);
    a = rnd() & 32'h00FFFFFC;
    d0 = rnd();
    prog(16'h2080, a, d0, 32'h0);
    idle(1);
    rd(4'h1); chk(rv & 16'h4800, 32'h0);
    wait_idle();
    exp_wr(a, d0);
    chk(eq.size(), 0);
    wr(4'h1, 16'h0880);
    wr(4'h1, 16'h8880);
    wait_idle();
    chk(eq.size(), 1);
    if (eq.size() > 0) chk(eq.pop_front(), 32'h3);
    rd(4'h2); chk(rv, 32'h0);
    rd(4'h3); chk(rv, 32'h0);
    $display("test erase done");
    erase();
    // Set protection selected beside erase differs from the suspended setup.
    wr(4'h1, 16'h0980);
    wr(4'h1, 16'h8980);
    wait_idle();
    rd(4'hA); chk(rv & 16'h0001, 32'h1);
    chk(eq.size(), 0);
    wr(4'hA, 16'h0000);
    $display("test resume done");
    prot(16'hFFFE, 16'hFFFF);
    rd(4'hC); chk(rv, 32'hFFFF);
    wr(4'hB, 16'hFFFC);
    prot(16'hFFFE, 16'hFFFF);
    rd(4'hC); chk(rv, 32'hFFFE);
    prot(16'hFFFF, 16'hFFFE);
    rd(4'hD); chk(rv, 32'hFFFE);
    idle(1);
    $display("test protect done");
    results();
  end
endmodule
